/* File: rtl/clmso_alu.sv */
// Combinational arithmetic for multiply and logical or
// Assumes operands come from registered state of the executor
`timescale 1ns/1ns
`include "clmso_cfg.svh"
module clmso_alu (
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic [7:0] flags_in,
  input wire logic is_mul,
  output logic [15:0] result,
  output logic [7:0] flags_out
);
  import clmso_pkg::*;
  // ===========================================
  // Result and flags
  always_comb begin
    flags_out = flags_in;
    if (is_mul) begin
      // (RULE_06) Unsigned 16-bit product
      result = {8'h00, op_a} * {8'h00, op_b};
      // (RULE_07) Product flag update
      flags_out[`CLMSO_FLAG_C] = (result > 16'd255);
      flags_out[`CLMSO_FLAG_Z] = (result == 16'h0000);
      flags_out[`CLMSO_FLAG_S] = result[15];
      flags_out[`CLMSO_FLAG_V] = 1'b0;
    end else begin
      // (RULE_10) Bitwise or
      result = {8'h00, op_a | op_b};
      // (RULE_11) Or flag update
      flags_out[`CLMSO_FLAG_Z] = (result[7:0] == 8'h00);
      flags_out[`CLMSO_FLAG_S] = result[7];
      flags_out[`CLMSO_FLAG_V] = 1'b0;
    end
  end
endmodule

/* File: rtl/clmso_cfg.svh */
// Constants for the instruction slice executor
// Assumes inclusion by the ALU and the executor files
`ifndef CLMSO_CFG_SVH
`define CLMSO_CFG_SVH
// Opcodes
`define CLMSO_OP_PREINC 8'hf3
`define CLMSO_OP_WMOV_RR 8'hc4
`define CLMSO_OP_WMOV_IR 8'hc5
`define CLMSO_OP_WMOV_IM 8'hc6
`define CLMSO_OP_MUL_R 8'h84
`define CLMSO_OP_MUL_IR 8'h85
`define CLMSO_OP_MUL_IM 8'h86
`define CLMSO_OP_NEXT 8'h0f
`define CLMSO_OP_IDLE 8'hff
`define CLMSO_OP_OR_RR 8'h42
`define CLMSO_OP_OR_RIR 8'h43
`define CLMSO_OP_OR_GG 8'h44
`define CLMSO_OP_OR_GIR 8'h45
`define CLMSO_OP_OR_IM 8'h46
`define CLMSO_OP_POP_R 8'h50
`define CLMSO_OP_POP_IR 8'h51
`define CLMSO_OP_USER_STACK_POP_DOWN 8'h92
`define CLMSO_OP_USER_STACK_POP_UP 8'h93
`define CLMSO_OP_PUSH 8'h70
// Cycle counts
`define CLMSO_CYC_PREINC 8'd14
`define CLMSO_CYC_WMOV 8'd8
`define CLMSO_CYC_MUL 8'd22
`define CLMSO_CYC_NEXT 8'd10
`define CLMSO_CYC_IDLE 8'd4
`define CLMSO_CYC_OR_RR 8'd4
`define CLMSO_CYC_OR 8'd6
`define CLMSO_CYC_STACK 8'd8
// Byte counts
`define CLMSO_LEN_1 3'd1
`define CLMSO_LEN_2 3'd2
`define CLMSO_LEN_3 3'd3
`define CLMSO_LEN_4 3'd4
// Flag bit positions
`define CLMSO_FLAG_C 7
`define CLMSO_FLAG_Z 6
`define CLMSO_FLAG_S 5
`define CLMSO_FLAG_V 4
`define CLMSO_FLAG_D 3
`define CLMSO_FLAG_H 2
// Reset values and pointer step
`define CLMSO_RST_FLAGS 8'h00
`define CLMSO_RST_SP 16'h0000
`define CLMSO_RST_IP 16'h0000
`define CLMSO_IP_STEP 16'h0002
`endif

/* File: rtl/clmso_exec.sv */
// Executor for one slice of an 8-bit instruction set
// Assumes decoded operands from the fetch stage and one-cycle memory reads
// Function
// (RULE_01) Pre-increment store bumps the pair, then writes; 0xf3, 2 bytes, 14 cycles.
// (RULE_02) Even pair address goes to program memory, odd to data memory.
// (RULE_03) Moves, jumps, idle, pops and push leave every flag alone.
// (RULE_04) Word move copies 16 bits into a pair; 0xc4-0xc6, 8 cycles.
// (RULE_05) High byte lands in the even register, low byte in the next.
// (RULE_06) Multiply even register by source, 16-bit product, high byte even; 22 cycles.
// (RULE_07) Multiply sets carry above 255, zero, sign, clears overflow.
// (RULE_08) Threaded jump loads counter from word at pointer, pointer plus two.
// (RULE_09) Idle 0xff changes nothing, one byte, four cycles.
// (RULE_10) Or stores bitwise or in destination with listed byte and cycle counts.
// (RULE_11) Or sets zero, sign from bit 7, clears overflow.
// (RULE_12) Pop loads from stack pointer, then increments it; 8 cycles.
// (RULE_13) Down pop reads via user pointer, then decrements it.
// (RULE_14) Up pop reads via user pointer, then increments it.
// (RULE_15) Push decrements pointer first, then writes source there.
// (RULE_16) Pair pre-increment carries from low into high register.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`include "clmso_cfg.svh"
module clmso_exec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_addr,
  input wire logic [7:0] src_addr,
  input wire logic [15:0] imm_word,
  input wire logic [15:0] pair_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] dst_value,
  input wire logic [15:0] src_word,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] prog_word,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [2:0] instr_len,
  output logic rf_we,
  output logic [7:0] rf_waddr,
  output logic [7:0] rf_wdata,
  output logic mem_we,
  output logic mem_re,
  output clmso_pkg::clmso_space_type mem_space,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic [7:0] flags,
  output logic [15:0] stack_ptr,
  output logic [15:0] instruction_pointer
);
  import clmso_pkg::*;

  typedef struct packed {
    clmso_state_type st;
    logic [7:0] op;
    logic [7:0] cnt;
    logic [7:0] cyc;
    logic [7:0] da;
    logic [7:0] sa;
    logic [15:0] word;
    logic [7:0] dv;
    logic [7:0] sv;
    logic [15:0] pair;
    logic [1:0] wstep;
    logic done;
    logic illegal;
    logic [2:0] len;
    logic rf_we;
    logic [7:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic mem_we;
    logic mem_re;
    clmso_space_type space;
    logic [15:0] maddr;
    logic [7:0] mwdata;
    logic pc_load;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [15:0] ip;
  } clmso_regs_type;

  clmso_regs_type state_reg;
  clmso_regs_type state_next;
  logic [15:0] alu_result;
  logic [7:0] alu_flags;

  // ===========================================
  // Decode helpers
  function automatic logic [7:0] cycles_of(input logic [7:0] op);
    case (op)
      `CLMSO_OP_PREINC: cycles_of = `CLMSO_CYC_PREINC;
      `CLMSO_OP_WMOV_RR, `CLMSO_OP_WMOV_IR, `CLMSO_OP_WMOV_IM: cycles_of = `CLMSO_CYC_WMOV;
      `CLMSO_OP_MUL_R, `CLMSO_OP_MUL_IR, `CLMSO_OP_MUL_IM: cycles_of = `CLMSO_CYC_MUL;
      `CLMSO_OP_NEXT: cycles_of = `CLMSO_CYC_NEXT;
      `CLMSO_OP_IDLE: cycles_of = `CLMSO_CYC_IDLE;
      `CLMSO_OP_OR_RR: cycles_of = `CLMSO_CYC_OR_RR;
      `CLMSO_OP_OR_RIR, `CLMSO_OP_OR_GG, `CLMSO_OP_OR_GIR, `CLMSO_OP_OR_IM: cycles_of = `CLMSO_CYC_OR;
      `CLMSO_OP_POP_R, `CLMSO_OP_POP_IR, `CLMSO_OP_USER_STACK_POP_DOWN, `CLMSO_OP_USER_STACK_POP_UP,
      `CLMSO_OP_PUSH: cycles_of = `CLMSO_CYC_STACK;
      default: cycles_of = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] length_of(input logic [7:0] op);
    case (op)
      `CLMSO_OP_NEXT, `CLMSO_OP_IDLE: length_of = `CLMSO_LEN_1;
      `CLMSO_OP_PREINC, `CLMSO_OP_OR_RR, `CLMSO_OP_OR_RIR, `CLMSO_OP_POP_R, `CLMSO_OP_POP_IR,
      `CLMSO_OP_PUSH: length_of = `CLMSO_LEN_2;
      `CLMSO_OP_WMOV_IM: length_of = `CLMSO_LEN_4;
      default: length_of = `CLMSO_LEN_3;
    endcase
  endfunction

  function automatic logic is_mul_op(input logic [7:0] op);
    is_mul_op = (op == `CLMSO_OP_MUL_R) || (op == `CLMSO_OP_MUL_IR) || (op == `CLMSO_OP_MUL_IM);
  endfunction

  function automatic clmso_space_type store_space(input logic [7:0] pair_addr);
    store_space = pair_addr[0] ? CLMSO_SP_DATA : CLMSO_SP_PROG;
  endfunction

  function automatic logic [7:0] pair_reg(input logic [7:0] pair_addr, input logic low_half);
    pair_reg = {pair_addr[7:1], low_half};
  endfunction

  // ===========================================
  // Arithmetic unit
  clmso_alu u_alu (
    .op_a(state_reg.dv),
    .op_b(state_reg.sv),
    .flags_in(state_reg.flags),
    .is_mul(is_mul_op(state_reg.op)),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // ===========================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.rf_we = 1'b0;
    state_next.mem_we = 1'b0;
    state_next.mem_re = 1'b0;
    state_next.pc_load = 1'b0;
    unique case (state_reg.st)
      CLMSO_IDLE: begin
        if (start) begin
          state_next.op = opcode;
          state_next.da = dst_addr;
          state_next.sa = src_addr;
          state_next.dv = dst_value;
          state_next.sv = src_value;
          state_next.word = src_word;
          state_next.pair = pair_value;
          state_next.len = length_of(opcode);
          state_next.cyc = cycles_of(opcode);
          state_next.cnt = 8'd1;
          state_next.wstep = 2'd0;
          state_next.illegal = (cycles_of(opcode) == 8'h00);
          state_next.st = (cycles_of(opcode) == 8'h00) ? CLMSO_DONE : CLMSO_READ;
          if (opcode == `CLMSO_OP_MUL_IM || opcode == `CLMSO_OP_OR_IM) begin
            state_next.sv = imm_word[7:0];
          end
          if (opcode == `CLMSO_OP_WMOV_IM) begin
            state_next.word = imm_word;
          end
        end
      end
      CLMSO_READ: begin
        state_next.cnt = state_reg.cnt + 8'd1;
        state_next.st = CLMSO_WRITE;
        unique case (state_reg.op)
          `CLMSO_OP_PREINC: begin
            // (RULE_16) Full 16-bit carry
            state_next.pair = state_reg.pair + 16'h0001;
          end
          `CLMSO_OP_POP_R, `CLMSO_OP_POP_IR: begin
            // (RULE_12) Read at stack pointer
            state_next.mem_re = 1'b1;
            state_next.space = CLMSO_SP_STACK;
            state_next.maddr = state_reg.sp;
          end
          `CLMSO_OP_USER_STACK_POP_DOWN, `CLMSO_OP_USER_STACK_POP_UP: begin
            // (RULE_13) Read at user pointer
            state_next.mem_re = 1'b1;
            state_next.space = CLMSO_SP_RF;
            state_next.maddr = {8'h00, state_reg.sv};
          end
          `CLMSO_OP_PUSH: begin
            // (RULE_15) Decrement before write
            state_next.sp = state_reg.sp - 16'h0001;
          end
          default: begin
          end
        endcase
      end
      CLMSO_WRITE: begin
        state_next.cnt = state_reg.cnt + 8'd1;
        state_next.st = CLMSO_WAIT;
        unique case (state_reg.op)
          `CLMSO_OP_PREINC: begin
            // (RULE_01) Write after increment
            state_next.mem_we = 1'b1;
            state_next.maddr = state_reg.pair;
            state_next.mwdata = state_reg.sv;
            // (RULE_02) Space from pair address parity
            state_next.space = store_space(state_reg.da);
            state_next.rf_we = 1'b1;
            state_next.rf_waddr = pair_reg(state_reg.da, 1'b0);
            state_next.rf_wdata = state_reg.pair[15:8];
            state_next.wstep = 2'd1;
            state_next.st = CLMSO_WRITE;
            if (state_reg.wstep == 2'd1) begin
              state_next.mem_we = 1'b0;
              state_next.rf_waddr = pair_reg(state_reg.da, 1'b1);
              state_next.rf_wdata = state_reg.pair[7:0];
              state_next.st = CLMSO_WAIT;
            end
          end
          `CLMSO_OP_WMOV_RR, `CLMSO_OP_WMOV_IR, `CLMSO_OP_WMOV_IM, `CLMSO_OP_MUL_R, `CLMSO_OP_MUL_IR,
          `CLMSO_OP_MUL_IM: begin
            // (RULE_04) Word copy, source untouched
            // (RULE_05) High byte to even register
            state_next.rf_we = 1'b1;
            state_next.rf_waddr = pair_reg(state_reg.da, state_reg.wstep[0]);
            if (is_mul_op(state_reg.op)) begin
              // (RULE_06) Product into the pair
              state_next.rf_wdata = state_reg.wstep[0] ? alu_result[7:0] : alu_result[15:8];
            end else begin
              state_next.rf_wdata = state_reg.wstep[0] ? state_reg.word[7:0] : state_reg.word[15:8];
            end
            state_next.wstep = 2'd1;
            state_next.st = (state_reg.wstep == 2'd1) ? CLMSO_WAIT : CLMSO_WRITE;
            if (is_mul_op(state_reg.op) && state_reg.wstep == 2'd1) begin
              // (RULE_07) Multiply flags
              state_next.flags = alu_flags;
            end
          end
          `CLMSO_OP_OR_RR, `CLMSO_OP_OR_RIR, `CLMSO_OP_OR_GG, `CLMSO_OP_OR_GIR, `CLMSO_OP_OR_IM: begin
            // (RULE_10) Store or result
            state_next.rf_we = 1'b1;
            state_next.rf_waddr = state_reg.da;
            state_next.rf_wdata = alu_result[7:0];
            // (RULE_11) Or flags
            state_next.flags = alu_flags;
          end
          `CLMSO_OP_NEXT: begin
            // (RULE_08) Jump through pointer
            state_next.pc_load = 1'b1;
            state_next.pc = prog_word;
            state_next.ip = state_reg.ip + `CLMSO_IP_STEP;
          end
          `CLMSO_OP_POP_R, `CLMSO_OP_POP_IR: begin
            // (RULE_12) Load then increment
            state_next.rf_we = 1'b1;
            state_next.rf_waddr = state_reg.da;
            state_next.rf_wdata = mem_rdata;
            state_next.sp = state_reg.sp + 16'h0001;
          end
          `CLMSO_OP_USER_STACK_POP_DOWN, `CLMSO_OP_USER_STACK_POP_UP: begin
            // (RULE_13) Load value, step pointer
            // (RULE_14) Direction from opcode
            state_next.rf_we = 1'b1;
            state_next.rf_waddr = state_reg.da;
            state_next.rf_wdata = mem_rdata;
            state_next.wstep = 2'd2;
            state_next.st = CLMSO_WRITE;
            if (state_reg.wstep == 2'd2) begin
              state_next.rf_waddr = state_reg.sa;
              if (state_reg.op == `CLMSO_OP_USER_STACK_POP_DOWN) begin
                state_next.rf_wdata = state_reg.sv - 8'd1;
              end else begin
                state_next.rf_wdata = state_reg.sv + 8'd1;
              end
              state_next.st = CLMSO_WAIT;
            end
          end
          `CLMSO_OP_PUSH: begin
            // (RULE_15) Write at new pointer
            state_next.mem_we = 1'b1;
            state_next.space = CLMSO_SP_STACK;
            state_next.maddr = state_reg.sp;
            state_next.mwdata = state_reg.sv;
          end
          default: begin
            // (RULE_09) Idle changes nothing
          end
        endcase
      end
      CLMSO_WAIT: begin
        // (RULE_03) Flags held outside multiply and or
        state_next.cnt = state_reg.cnt + 8'd1;
        if (state_reg.cnt >= state_reg.cyc - 8'd1) begin
          state_next.st = CLMSO_DONE;
        end
      end
      CLMSO_DONE: begin
        state_next.done = 1'b1;
        state_next.st = CLMSO_IDLE;
      end
      default: begin
        state_next.st = CLMSO_IDLE;
      end
    endcase
  end

  // ===========================================
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.st <= CLMSO_IDLE;
      state_reg.flags <= `CLMSO_RST_FLAGS;
      state_reg.sp <= `CLMSO_RST_SP;
      state_reg.ip <= `CLMSO_RST_IP;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.st != CLMSO_IDLE);
  assign done = state_reg.done;
  assign illegal = state_reg.illegal;
  assign instr_len = state_reg.len;
  assign rf_we = state_reg.rf_we;
  assign rf_waddr = state_reg.rf_waddr;
  assign rf_wdata = state_reg.rf_wdata;
  assign mem_we = state_reg.mem_we;
  assign mem_re = state_reg.mem_re;
  assign mem_space = state_reg.space;
  assign mem_addr = state_reg.maddr;
  assign mem_wdata = state_reg.mwdata;
  assign pc_load = state_reg.pc_load;
  assign pc_value = state_reg.pc;
  assign flags = state_reg.flags;
  assign stack_ptr = state_reg.sp;
  assign instruction_pointer = state_reg.ip;
endmodule

/* File: rtl/clmso_pkg.sv */
// Types for the instruction slice executor
// Assumes the constants header is compiled alongside
package clmso_pkg;
  typedef enum logic [2:0] {
    CLMSO_IDLE = 3'b000,
    CLMSO_READ = 3'b001,
    CLMSO_WRITE = 3'b010,
    CLMSO_WAIT = 3'b011,
    CLMSO_DONE = 3'b100
  } clmso_state_type;
  typedef enum logic [1:0] {
    CLMSO_SP_RF = 2'b00,
    CLMSO_SP_PROG = 2'b01,
    CLMSO_SP_DATA = 2'b10,
    CLMSO_SP_STACK = 2'b11
  } clmso_space_type;
endpackage

/* File: tb/clmso_mem_model.sv */
// Memory and register model on the far side of the executor
// Assumes reads answered while the strobe stands; only the low address byte is decoded
`timescale 1ns/1ns
module clmso_mem_model (
  input wire logic clk,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [0:255];
  logic [7:0] rd = 8'h5a;
  initial begin
    for (int i = 0; i < 256; i++) begin
      store[i] = 8'h00;
    end
  end
  // Read data valid while the strobe stands, toggling otherwise
  always @(posedge clk) begin
    if (mem_we) begin
      store[mem_addr[7:0]] <= mem_wdata;
    end
    rd <= ~rd;
  end
  assign mem_rdata = mem_re ? store[mem_addr[7:0]] : rd;
endmodule

/* File: tb/clmso_props.sv */
// Port checker for the executor
// Assumes binding to clmso_exec
`timescale 1ns/1ns
module clmso_props
import clmso_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_addr,
  input wire logic [15:0] pair_value,
  input wire logic rf_we,
  input wire logic [7:0] rf_waddr,
  input wire logic [7:0] rf_wdata,
  input wire logic mem_we,
  input wire clmso_space_type mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] flags,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] instruction_pointer
);
  logic [7:0] op_q, fl_s, dst_s;
  logic [15:0] sp_s, ip_s, pr_s, pn;
  assign pn = pr_s + 16'h0001;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_q <= 8'h00;
    end else if (start && !busy) begin
      op_q <= opcode;
      fl_s <= flags;
      dst_s <= dst_addr;
      sp_s <= stack_ptr;
      ip_s <= instruction_pointer;
      pr_s <= pair_value;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wb;
    rf_we && rf_waddr == {dst_s[7:1], 1'b0} && rf_wdata == pn[15:8]
    ##1 rf_we && rf_waddr == {dst_s[7:1], 1'b1} && rf_wdata == pn[7:0];
  endsequence
  property p_idle;
    start && !busy && opcode == 8'hff |-> ##[5:6] done;
  endproperty
  property p_mul;
    start && !busy && opcode inside {8'h84, 8'h85, 8'h86} |-> ##[23:24] done;
  endproperty
  property p_noflag;
    busy && op_q inside {8'hf3, 8'hc4, 8'hc5, 8'hc6, 8'h0f, 8'hff, 8'h50, 8'h51, 8'h92, 8'h93, 8'h70} |=> $stable(flags);
  endproperty
  property p_next;
    done && op_q == 8'h0f |-> instruction_pointer == ip_s + 16'h0002;
  endproperty
  property p_pop;
    done && op_q inside {8'h50, 8'h51} |-> stack_ptr == sp_s + 16'h0001;
  endproperty
  property p_push;
    mem_we && op_q == 8'h70 |-> mem_addr == sp_s - 16'h0001 && mem_space == CLMSO_SP_STACK;
  endproperty
  property p_space;
    mem_we && op_q == 8'hf3 |-> mem_addr == pn && mem_space == (dst_s[0] ? CLMSO_SP_DATA : CLMSO_SP_PROG);
  endproperty
  property p_wb;
    mem_we && op_q == 8'hf3 |-> s_wb;
  endproperty
  property p_mflag;
    done && op_q inside {8'h84, 8'h85, 8'h86} |-> !flags[4] && flags[3:2] == fl_s[3:2];
  endproperty
  property p_oflag;
    done && op_q inside {[8'h42:8'h46]} |-> !flags[4] && flags[7] == fl_s[7] && flags[3:2] == fl_s[3:2];
  endproperty
  a_idle: assert property (p_idle) else $error("idle length wrong");
  a_mul: assert property (p_mul) else $error("multiply length wrong");
  a_noflag: assert property (p_noflag) else $error("flags moved");
  a_next: assert property (p_next) else $error("pointer step wrong");
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  a_push: assert property (p_push) else $error("push address wrong");
  a_space: assert property (p_space) else $error("store space wrong");
  a_wb: assert property (p_wb) else $error("pair writeback wrong");
  a_mflag: assert property (p_mflag) else $error("multiply flags wrong");
  a_oflag: assert property (p_oflag) else $error("or flags wrong");
endmodule
bind clmso_exec clmso_props u_props (.clk(clk), .sys_rst(sys_rst), .start(start), .busy(busy), .done(done),
  .opcode(opcode), .dst_addr(dst_addr), .pair_value(pair_value), .rf_we(rf_we), .rf_waddr(rf_waddr),
  .rf_wdata(rf_wdata), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr), .flags(flags),
  .stack_ptr(stack_ptr), .instruction_pointer(instruction_pointer));

/* File: tb/tb_top.sv */
// Self-checking bench for the executor
// Assumes the memory model answers reads
`timescale 1ns/1ns
module tb_top;
  import clmso_pkg::*;
  typedef struct packed {logic [7:0] op; logic [7:0] a; logic [7:0] b; logic [7:0] cyc; logic [2:0] len;} clmso_row_type;
  logic clk, sys_rst, start, busy, done, illegal, rf_we, mem_we, mem_re, pc_load;
  logic [7:0] opcode, dst_addr, src_addr, src_value, dst_value, mem_rdata, rf_waddr, rf_wdata, mem_wdata, flags, fexp;
  logic [15:0] imm_word, pair_value, src_word, prog_word, mem_addr, pc_value, stack_ptr, instruction_pointer, p, pcq;
  logic [2:0] instr_len;
  clmso_space_type mem_space;
  int failures, compares, cyc_n;
  logic [15:0] rq[$];
  logic [25:0] mq[$];
  clmso_row_type r;
  clmso_row_type rows [8] = '{'{8'h84, 8'h20, 8'h09, 8'd22, 3'd3}, '{8'h85, 8'h00, 8'hc0, 8'd22, 3'd3},
    '{8'h86, 8'hff, 8'hff, 8'd22, 3'd3}, '{8'h42, 8'h15, 8'h2a, 8'd4, 3'd2}, '{8'h43, 8'h00, 8'h00, 8'd6, 3'd2},
    '{8'h44, 8'h80, 8'h01, 8'd6, 3'd3}, '{8'h45, 8'h37, 8'h08, 8'd6, 3'd3}, '{8'h46, 8'h08, 8'h02, 8'd6, 3'd3}};
  logic [15:0] raddr;
  clmso_exec dut (.clk(clk), .sys_rst(sys_rst), .start(start), .opcode(opcode), .dst_addr(dst_addr),
    .src_addr(src_addr), .imm_word(imm_word), .pair_value(pair_value), .src_value(src_value),
    .dst_value(dst_value), .src_word(src_word), .mem_rdata(mem_rdata), .prog_word(prog_word), .busy(busy),
    .done(done), .illegal(illegal), .instr_len(instr_len), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_space(mem_space), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .pc_load(pc_load), .pc_value(pc_value), .flags(flags), .stack_ptr(stack_ptr),
    .instruction_pointer(instruction_pointer));
  clmso_mem_model mem (.clk(clk), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  always #50 clk = ~clk;
  // ==========
  // Monitor and timeout
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      failures++;
      finish_test();
    end
    if (rf_we) rq.push_back({rf_waddr, rf_wdata});
    if (mem_we) mq.push_back({mem_space, mem_addr, mem_wdata});
    if (pc_load) pcq = pc_value;
    if (mem_re) raddr = mem_addr;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] cyc, input logic [2:0] len);
    int c;
    rq.delete();
    mq.delete();
    opcode <= op;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 40) begin
      @(negedge clk);
      c++;
    end
    chk("cycles", {8'h00, cyc + 8'd1}, c[15:0]);
    if (len != 3'd0) chk("len", {13'h0, len}, {13'h0, instr_len});
    chk("flags", {8'h00, fexp}, {8'h00, flags});
    @(posedge clk);
  endtask
  task automatic preinc(input logic [15:0] pr, input logic [7:0] da, input logic [1:0] sp);
    logic [15:0] n;
    n = pr + 16'h0001;
    pair_value <= pr;
    src_value <= 8'h7f;
    dst_addr <= da;
    run(8'hf3, 8'd14, 3'd2);
    chk("paddr", n, mq[0][23:8]);
    chk("pspace", {14'h0, sp}, {14'h0, mq[0][25:24]});
    chk("pdata", 16'h007f, {8'h00, mq[0][7:0]});
    chk("pwb_hi", {8'h06, n[15:8]}, rq[0]);
    chk("pwb_lo", {8'h07, n[7:0]}, rq[1]);
  endtask
  task automatic finish_test();
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    {clk, start, opcode, src_addr, imm_word, pair_value, src_value, dst_value, src_word, prog_word} = '0;
    {failures, compares, cyc_n, fexp, pcq, raddr} = '0;
    sys_rst = 1'b1;
    dst_addr = 8'h10;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("rst", 16'h0000, {flags, 7'h0, busy} | stack_ptr | instruction_pointer);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      dst_value <= r.a;
      src_value <= r.b;
      imm_word <= {8'h00, r.b};
      p = r.op[7] ? {8'h00, r.a} * {8'h00, r.b} : {8'h00, r.a | r.b};
      fexp[6] = (p == 16'h0000);
      fexp[4] = 1'b0;
      fexp[5] = r.op[7] ? p[15] : p[7];
      if (r.op[7]) fexp[7] = (p > 16'd255);
      run(r.op, r.cyc, r.len);
      if (r.op[7]) begin
        chk("prod_hi", {8'h10, p[15:8]}, rq[0]);
        chk("prod_lo", {8'h11, p[7:0]}, rq[1]);
      end else begin
        chk("or", {8'h10, p[7:0]}, rq[0]);
      end
    end
    preinc(16'h21ff, 8'h06, 2'b01);
    preinc(16'h21ff, 8'h07, 2'b10);
    for (int i = 0; i < 3; i++) begin
      src_word <= 16'h0612 + 16'(i);
      imm_word <= 16'h0612 + 16'(i);
      dst_addr <= 8'h06;
      run(8'hc4 + 8'(i), 8'd8, (i == 2) ? 3'd4 : 3'd3);
      chk("wmov_hi", 16'h0606, rq[0]);
      chk("wmov_lo", {8'h07, 8'h12 + 8'(i)}, rq[1]);
    end
    prog_word <= 16'hbeef;
    run(8'h0f, 8'd10, 3'd1);
    chk("pc", 16'hbeef, pcq);
    chk("ip", 16'h0002, instruction_pointer);
    run(8'hff, 8'd4, 3'd1);
    chk("idle", 16'h0000, 16'(rq.size() + mq.size()));
    src_value <= 8'h4f;
    run(8'h70, 8'd8, 3'd2);
    chk("push", 16'hffff, mq[0][23:8] & stack_ptr);
    chk("push_d", 16'h034f, {6'h0, mq[0][25:24], mq[0][7:0]});
    dst_addr <= 8'h20;
    run(8'h50, 8'd8, 3'd2);
    chk("pop", 16'h204f, rq[0]);
    chk("pop_sp", 16'h0000, stack_ptr);
    chk("pop_ra", 16'hffff, raddr);
    mem.store[8'h42] = 8'h6f;
    mem.store[8'h01] = 8'h70;
    for (int j = 0; j < 2; j++) begin
      src_addr <= j ? 8'h30 : 8'h00;
      src_value <= j ? 8'h01 : 8'h42;
      dst_addr <= 8'h02;
      run(8'h92 + 8'(j), 8'd8, 3'd3);
      chk("upop", j ? 16'h0270 : 16'h026f, rq[0]);
      chk("uptr", j ? 16'h3002 : 16'h0041, rq[1]);
      chk("upop_ra", j ? 16'h0001 : 16'h0042, raddr);
    end
    run(8'h00, 8'd1, 3'd0);
    chk("illegal", 16'h0001, {15'h0, illegal});
    finish_test();
  end
endmodule
